// ### cmpctl_fe_model.sv
// front end model: sense levels per channel and the resolved pin wire.
// assumes the bench sets levels through set_sense.
`timescale 1ns/10ps
`default_nettype none
module cmpctl_fe_model
#(
  parameter int NCH = 4,
  parameter int DATA_W = 12
)
(
  // clock
  input wire logic clk_i,
  // comparator pins
  input wire logic [NCH-1:0] pin_i,
  input wire logic [NCH-1:0] pin_oe_i,
  // sense levels and wire
  output logic [DATA_W-1:0] sense_code_o [NCH],
  output logic [NCH-1:0] pin_wire_o
);
  assign pin_wire_o = (pin_oe_i & pin_i) | ~pin_oe_i;
  initial
  begin
    foreach (sense_code_o[k])
      sense_code_o[k] = '0;
  end
  task set_sense(input int ch, input logic [DATA_W-1:0] v);
    @(posedge clk_i);
    sense_code_o[ch] <= v;
  endtask : set_sense
endmodule : cmpctl_fe_model
`default_nettype wire

// ### cmpctl_params.svh
// register map, field positions, reset values and encodings of the
// channel reference and comparator control block.
// assumes a byte-addressed 32-bit classic Wishbone register bus.
`ifndef CMPCTL_PARAMS_SVH
`define CMPCTL_PARAMS_SVH

// common registers (byte offsets)
`define CC_COMMON_OFS 8'h00
`define CC_MODE_OFS 8'h04
`define CC_TRIG_OFS 8'h08
`define CC_STAT_OFS 8'h0c

// channel c lives at 8'h20 * (c + 1); word index inside a channel
`define CC_CH_VCMP 3'h0
`define CC_CH_CMODE 3'h1
`define CC_CH_ICFG 3'h2
`define CC_CH_DATA 3'h3
`define CC_CH_MHI 3'h4
`define CC_CH_MLO 3'h5
`define CC_CH_NREG 6

// common configuration fields
`define CC_INTREF_BIT 0
`define CC_IPD_LSB 4
`define CC_VPD_LSB 8
`define CC_COMMON_RST 32'h0000_fff0
`define CC_COMMON_WMASK 32'h0000_fff1

// device mode configuration
`define CC_MIDIS_BIT 0
`define CC_MODE_WMASK 32'h0000_0001

// channel voltage/comparator configuration fields
`define CC_GAIN_LSB 0
`define CC_CMPEN_BIT 4
`define CC_OD_BIT 5
`define CC_OUTEN_BIT 6
`define CC_INV_BIT 7
`define CC_HIZD_BIT 8
`define CC_VCMP_WMASK 32'h0000_01f7
`define CC_CMODE_WMASK 32'h0000_0003
`define CC_ICFG_WMASK 32'h0000_0003
`define CC_CODE_WMASK 32'h0000_0fff

// status fields: level, held, window
`define CC_ST_LVL_LSB 0
`define CC_ST_HELD_LSB 4
`define CC_ST_WIN_LSB 8

// voltage power-down encodings
`define CC_VPD_UP 2'h0
`define CC_VPD_HIZ 2'h3

`endif

// ### cmpctl_pkg.sv
// types shared by the channel reference and comparator control block.
// assumes cmpctl_params.svh for the numeric layout.
package cmpctl_pkg;

  typedef enum logic [1:0] {
    CC_REF_EXT = 2'h0,
    CC_REF_VDD = 2'h1,
    CC_REF_INT = 2'h2
  } cmpctl_ref_t;

  typedef enum logic [2:0] {
    CC_G1X = 3'h0,
    CC_G1X_VDD = 3'h1,
    CC_G1P5X = 3'h2,
    CC_G2X = 3'h3,
    CC_G3X = 3'h4,
    CC_G4X = 3'h5
  } cmpctl_gain_t;

  typedef enum logic [1:0] {
    CC_CM_NORMAL = 2'h0,
    CC_CM_HYST = 2'h1,
    CC_CM_WINDOW = 2'h2,
    CC_CM_INVALID = 2'h3
  } cmpctl_cmode_t;

  typedef enum logic [1:0] {
    CC_CS_LOW = 2'h0,
    CC_CS_HIGH = 2'h1,
    CC_CS_HELD_LOW = 2'h2,
    CC_CS_HELD_HIGH = 2'h3
  } cmpctl_cst_t;

  typedef struct packed {
    cmpctl_ref_t ref_sel;
    cmpctl_gain_t gain;
    logic vout_on;
    logic iout_on;
    logic [1:0] range;
    logic sense_highz;
    logic cmp_on;
    logic [7:0] iout_code;
  } cmpctl_chan_t;

endpackage : cmpctl_pkg

// ### cmpctl_props.sv
// concurrent checks on the reference and comparator control block.
// assumes a bind onto cmpctl_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module cmpctl_props
  import cmpctl_pkg::*;
#(
  parameter int NCH = 4,
  parameter int DATA_W = 12
)
(
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_ack_o,
  // front end and pins
  input wire logic int_ref_en_o,
  input wire logic mode_input_disable_o,
  input wire cmpctl_chan_t chan_o [NCH],
  input wire logic [DATA_W-1:0] code_o [NCH],
  input wire logic [NCH-1:0] cmp_pin_oe_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic wr0 = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h00;
  wire logic wr4 = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 8'h04;
  AST_ACK_NEXT: assert property (req |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RST_REF: assert property ($past(rst_i) |-> !int_ref_en_o && !mode_input_disable_o)
    else $error("reference or mode bit set out of reset");
  AST_INTREF_CAUSE: assert property ($rose(int_ref_en_o) |-> $past(wr0) || $past(wr0, 2))
    else $error("internal reference on without a write");
  AST_MIDIS_CAUSE: assert property ($changed(mode_input_disable_o) |-> $past(wr4) || $past(wr4, 2))
    else $error("mode disable moved without a write");
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    AST_RST_HIZ: assert property ($past(rst_i) |-> chan_o[i].sense_highz && !cmp_pin_oe_o[i])
      else $error("sense input not high-z out of reset");
    AST_GAIN_FORCED: assert property (chan_o[i].ref_sel != CC_REF_INT |-> chan_o[i].gain == CC_G1X)
      else $error("gain not 1x on external or supply reference");
    AST_GAIN_INT: assert property (chan_o[i].ref_sel == CC_REF_INT |-> chan_o[i].gain inside {CC_G1P5X, CC_G2X, CC_G3X, CC_G4X})
      else $error("bad gain on internal reference");
    AST_IOUT_CODE: assert property (chan_o[i].iout_code == code_o[i][7:0])
      else $error("current code differs from channel code");
    AST_PIN_CMP: assert property (cmp_pin_oe_o[i] |-> chan_o[i].cmp_on || $past(chan_o[i].cmp_on) || $past(chan_o[i].cmp_on, 2))
      else $error("pin driven with comparator off");
  end
  cover property ($rose(int_ref_en_o));
  cover property ($rose(chan_o[1].iout_on));
  cover property ($rose(cmp_pin_oe_o[2]));
endmodule : cmpctl_props
`default_nettype wire

// ### cmpctl_top.sv
// reference select, output mode and comparator control for a quad DAC.
// assumes a classic Wishbone master and a digitised feedback sense code
// per channel from the analog front end.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`include "cmpctl_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cmpctl_top
  import cmpctl_pkg::*;
#(
  parameter int NCH = 4,
  parameter int DATA_W = 12
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // analog front end
  input wire logic [DATA_W-1:0] sense_code_i [NCH],
  output logic int_ref_en_o,
  output logic mode_input_disable_o,
  output cmpctl_chan_t chan_o [NCH],
  output logic [DATA_W-1:0] code_o [NCH],
  // comparator pins
  output logic [NCH-1:0] cmp_pin_o,
  output logic [NCH-1:0] cmp_pin_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration check on resolution and channel count
  if (!(DATA_W == 8 || DATA_W == 10 || DATA_W == 12) || NCH < 1 || NCH > 4)
  begin : g_bad_cfg
    $error("cmpctl_top: DATA_W must be 8, 10 or 12 and NCH 1 to 4");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] common_q;
  logic [31:0] mode_q;
  logic [3:0] clr_q;
  logic [31:0] ch_q [NCH][`CC_CH_NREG];
  logic [31:0] ch_rd [NCH];
  logic [3:0] st_lvl;
  logic [3:0] st_held;
  logic [3:0] st_win;
  logic [NCH-1:0] pin_d;
  logic [NCH-1:0] oe_d;
  cmpctl_chan_t chan_d [NCH];

  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire hit_common = wb_adr_i == `CC_COMMON_OFS;
  wire hit_mode = wb_adr_i == `CC_MODE_OFS;
  wire hit_trig = wb_adr_i == `CC_TRIG_OFS;
  wire hit_stat = wb_adr_i == `CC_STAT_OFS;
  wire [2:0] ch_slot = wb_adr_i[7:5];
  wire [2:0] ch_idx = wb_adr_i[4:2];
  wire ch_sel_ok = ch_slot != 3'h0 && 32'(ch_slot) <= NCH &&
                   32'(ch_idx) < `CC_CH_NREG && wb_adr_i[1:0] == 2'h0;
  wire [1:0] ch_num = 2'(ch_slot - 3'h1);
  wire [31:0] stat_rd = {20'h0, st_win, st_held, st_lvl};
  wire [31:0] ch_word = ch_sel_ok ? ch_rd[ch_num] : 32'h0;
  wire [31:0] rd_mux = hit_common ? common_q :
                       hit_mode ? mode_q :
                       hit_stat ? stat_rd : ch_word;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [31:0] bm,
                                        input logic [31:0] wm);
    merge = (old & ~bm) | (val & bm & wm);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // bus slave and common registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      // internal reference off, every current output and voltage output powered down
      common_q <= `CC_COMMON_RST;
      mode_q <= 32'h0;
      clr_q <= 4'h0;
    end
    else
    begin
      ack_q <= req;
      if (req)
        rdat_q <= rd_mux;
      if (wr && hit_common)
        common_q <= merge(common_q, wb_dat_i, wmask, `CC_COMMON_WMASK);
      if (wr && hit_mode)
        mode_q <= merge(mode_q, wb_dat_i, wmask, `CC_MODE_WMASK);
      clr_q <= (wr && hit_trig && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one control set per channel
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    cmpctl_cst_t cs_q;
    cmpctl_cst_t cs_d;
    cmpctl_ref_t ref_sel;
    cmpctl_gain_t gain_eff;
    wire [31:0] vcmp = ch_q[c][`CC_CH_VCMP];
    wire [2:0] gain_raw = vcmp[`CC_GAIN_LSB +: 3];
    wire cmp_en = vcmp[`CC_CMPEN_BIT];
    wire od = vcmp[`CC_OD_BIT];
    wire out_en = vcmp[`CC_OUTEN_BIT];
    wire inv = vcmp[`CC_INV_BIT];
    wire hiz_dis = vcmp[`CC_HIZD_BIT];
    wire [1:0] mode_raw = ch_q[c][`CC_CH_CMODE][1:0];
    wire [DATA_W-1:0] data = ch_q[c][`CC_CH_DATA][DATA_W-1:0];
    wire [DATA_W-1:0] mhi = ch_q[c][`CC_CH_MHI][DATA_W-1:0];
    wire [DATA_W-1:0] mlo = ch_q[c][`CC_CH_MLO][DATA_W-1:0];
    wire [DATA_W-1:0] sense = sense_code_i[c];
    wire ipd = common_q[`CC_IPD_LSB + c];
    wire [1:0] vpd = common_q[`CC_VPD_LSB + 2 * c +: 2];
    wire vout_on = vpd == `CC_VPD_UP && ipd;
    wire iout_on = !ipd && vpd == `CC_VPD_HIZ;
    // comparator only on an active voltage channel
    wire cmp_act = vout_on && cmp_en;
    // mode decode, invalid falls to normal
    wire is_hyst = mode_raw == CC_CM_HYST;
    wire is_win = mode_raw == CC_CM_WINDOW;
    wire above_hi = sense > mhi;
    wire below_lo = sense < mlo;
    wire in_win = !above_hi && !below_lo;
    // latching when a margin sits at the code limit
    wire latch_md = is_hyst && (&mhi || mlo == '0);
    wire clr_ok = clr_q[c] && in_win;
    // normal compare against the raw channel data code
    wire norm_hi = sense > data;
    wire level = cs_q == CC_CS_HIGH || cs_q == CC_CS_HELD_HIGH;
    wire drive = level ^ inv;

    always_comb
    begin
      case (gain_raw)
        CC_G1X_VDD: ref_sel = CC_REF_VDD;
        CC_G1P5X, CC_G2X, CC_G3X, CC_G4X: ref_sel = CC_REF_INT;
        default: ref_sel = CC_REF_EXT;
      endcase
      gain_eff = ref_sel == CC_REF_INT ? cmpctl_gain_t'(gain_raw) : CC_G1X;
    end

    // comparator level machine
    always_comb
    begin
      cs_d = norm_hi ? CC_CS_HIGH : CC_CS_LOW;
      if (cmp_act && is_win)
        cs_d = in_win ? CC_CS_HIGH : CC_CS_LOW;
      else if (cmp_act && is_hyst)
      begin
        case (cs_q)
          CC_CS_LOW: cs_d = !above_hi ? CC_CS_LOW :
                            latch_md ? CC_CS_HELD_HIGH : CC_CS_HIGH;
          CC_CS_HIGH: cs_d = !below_lo ? CC_CS_HIGH :
                             latch_md ? CC_CS_HELD_LOW : CC_CS_LOW;
          // held level released by the clear pulse while the sense is inside the window
          CC_CS_HELD_HIGH: cs_d = clr_ok ? CC_CS_LOW : CC_CS_HELD_HIGH;
          CC_CS_HELD_LOW: cs_d = clr_ok ? CC_CS_HIGH : CC_CS_HELD_LOW;
          default: cs_d = CC_CS_LOW;
        endcase
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        cs_q <= CC_CS_LOW;
        for (int r = 0; r < `CC_CH_NREG; r++)
          ch_q[c][r] <= 32'h0;
      end
      else
      begin
        cs_q <= cs_d;
        if (wr && ch_sel_ok && 32'(ch_num) == c)
        begin
          case (ch_idx)
            `CC_CH_VCMP: ch_q[c][`CC_CH_VCMP] <=
              merge(vcmp, wb_dat_i, wmask, `CC_VCMP_WMASK);
            `CC_CH_CMODE: ch_q[c][`CC_CH_CMODE] <=
              merge(ch_q[c][`CC_CH_CMODE], wb_dat_i, wmask, `CC_CMODE_WMASK);
            `CC_CH_ICFG: ch_q[c][`CC_CH_ICFG] <=
              merge(ch_q[c][`CC_CH_ICFG], wb_dat_i, wmask, `CC_ICFG_WMASK);
            default: ch_q[c][ch_idx] <=
              merge(ch_q[c][ch_idx], wb_dat_i, wmask,
                    `CC_CODE_WMASK >> (12 - DATA_W));
          endcase
        end
      end
    end

    assign ch_rd[c] = ch_q[c][ch_idx];
    assign st_lvl[c] = level;
    assign st_held[c] = cs_q[1];
    assign st_win[c] = cmp_act && is_win && in_win;

    // pin style: push-pull or open-drain, inverted on demand
    assign pin_d[c] = cmp_act && out_en && !is_win && !od && drive;
    assign oe_d[c] = cmp_act && out_en && !is_win && (!od || !drive);

    always_comb
    begin
      chan_d[c].ref_sel = ref_sel;
      chan_d[c].gain = gain_eff;
      chan_d[c].vout_on = vout_on;
      chan_d[c].iout_on = iout_on;
      chan_d[c].range = ch_q[c][`CC_CH_ICFG][1:0];
      chan_d[c].sense_highz = !hiz_dis;
      chan_d[c].cmp_on = cmp_act;
      // current code is the low eight bits
      chan_d[c].iout_code = data[7:0];
    end
  end

  for (genvar c = NCH; c < 4; c++)
  begin : g_unused
    assign st_lvl[c] = 1'b0;
    assign st_held[c] = 1'b0;
    assign st_win[c] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // output flops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      int_ref_en_o <= 1'b0;
      mode_input_disable_o <= 1'b0;
      cmp_pin_o <= '0;
      cmp_pin_oe_o <= '0;
      for (int c = 0; c < NCH; c++)
      begin
        chan_o[c] <= '0;
        // sense input starts high-z, matching the disable bit at 0
        chan_o[c].sense_highz <= 1'b1;
        code_o[c] <= '0;
      end
    end
    else
    begin
      int_ref_en_o <= common_q[`CC_INTREF_BIT];
      mode_input_disable_o <= mode_q[`CC_MIDIS_BIT];
      cmp_pin_o <= pin_d;
      cmp_pin_oe_o <= oe_d;
      for (int c = 0; c < NCH; c++)
      begin
        chan_o[c] <= chan_d[c];
        code_o[c] <= ch_q[c][`CC_CH_DATA][DATA_W-1:0];
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule : cmpctl_top

`default_nettype wire

// ### cmpctl_top_tb.sv
// self-checking bench for the reference and comparator control block.
// assumes cmpctl_fe_model and cmpctl_props beside it.
`timescale 1ns/10ps
`default_nettype none
module cmpctl_top_tb import cmpctl_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rv;
  logic ack, iref, midis;
  cmpctl_chan_t chan [4];
  logic [11:0] code [4];
  logic [11:0] sense [4];
  logic [3:0] pin, oe, pwire;
  int failures = 0;
  int compares = 0;
  initial
    forever #2.5 clk_i = ~clk_i;
  cmpctl_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sense_code_i(sense), .int_ref_en_o(iref),
    .mode_input_disable_o(midis), .chan_o(chan), .code_o(code), .cmp_pin_o(pin),
    .cmp_pin_oe_o(oe));
  cmpctl_fe_model i_fe (.clk_i(clk_i), .pin_i(pin), .pin_oe_i(oe),
    .sense_code_o(sense), .pin_wire_o(pwire));
  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // waits for ack under a bound, read data taken at that edge
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    rv = rdat;
    req <= 1'b0;
    if (ack !== 1'b1)
    begin
      failures++;
      end_sim;
    end
    repeat (3) @(posedge clk_i);
  endtask : wb
  task sns(input int ch, input logic [11:0] v);
    i_fe.set_sense(ch, v);
    repeat (4) @(posedge clk_i);
  endtask : sns
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    wb(1'b0, 8'h00, 32'h0);
    chk("common", 32'h0000_fff0, rv);
    chk("ref0", CC_REF_EXT, chan[0].ref_sel);
    chk("hiz3", 1'b1, chan[3].sense_highz);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 32'h0);
    chk("unmapped", 32'h0, rv);
    $display("test reset done");
  endtask : t_reset
  task t_ref;
    logic [2:0] g;
    wb(1'b1, 8'h00, 32'h0000_fff1);
    chk("iref", 1'b1, iref);
    for (int k = 0; k < 8; k++)
    begin
      wb(1'b1, 8'h20, k);
      g = (k >= 2 && k <= 5) ? k[2:0] : 3'h0;
      chk("ref", k == 1 ? CC_REF_VDD : g != 0 ? CC_REF_INT : CC_REF_EXT, chan[0].ref_sel);
      chk("gain", g, chan[0].gain);
    end
    $display("test reference done");
  endtask : t_ref
  task t_modes;
    wb(1'b1, 8'h48, 32'h0);
    wb(1'b1, 8'h00, 32'h0000_fcd1);
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h48, 32'h2);
    wb(1'b1, 8'h4c, 32'h0000_01ff);
    wb(1'b1, 8'h2c, 32'hffff_ffff);
    chk("midis", 1'b1, midis);
    chk("mode0", 2'b10, {chan[0].vout_on, chan[0].iout_on});
    chk("mode1", 2'b01, {chan[1].vout_on, chan[1].iout_on});
    chk("range1", 2'h2, chan[1].range);
    chk("icode1", 8'hff, chan[1].iout_code);
    chk("code0", 12'hfff, code[0]);
    $display("test modes done");
  endtask : t_modes
  task t_pin;
    logic [23:0] tv [9];
    tv = '{24'h050093, 24'h050012, 24'h0d0092, 24'h070091, 24'h070012,
      24'h010091, 24'h040091, 24'h050393, 24'h150312};
    // channels 2 and 3 to voltage mode so the comparator can run
    wb(1'b1, 8'h00, 32'h0000_0cd1);
    wb(1'b1, 8'h6c, 32'h800);
    foreach (tv[k])
    begin
      wb(1'b1, 8'h60, tv[k][23:12]);
      wb(1'b1, 8'h64, tv[k][11:8]);
      sns(2, {tv[k][7:4], 8'h00});
      chk("oe2", tv[k][1], oe[2]);
      chk("wire2", tv[k][0], pwire[2]);
    end
    chk("hiz2", 1'b0, chan[2].sense_highz);
    wb(1'b1, 8'h70, 32'ha00);
    wb(1'b1, 8'h74, 32'h400);
    wb(1'b1, 8'h64, 32'h2);
    sns(2, 12'h900);
    wb(1'b0, 8'h0c, 32'h0);
    chk("window2", 1'b1, rv[10]);
    $display("test pin done");
  endtask : t_pin
  task t_latch;
    wb(1'b1, 8'h8c, 32'h0);
    wb(1'b1, 8'h90, 32'hfff);
    wb(1'b1, 8'h94, 32'h400);
    wb(1'b1, 8'h80, 32'h050);
    sns(3, 12'h800);
    wb(1'b1, 8'h84, 32'h1);
    chk("start3", 1'b1, pwire[3]);
    sns(3, 12'h100);
    chk("fall3", 1'b0, pwire[3]);
    sns(3, 12'h800);
    chk("held3", 1'b0, pwire[3]);
    wb(1'b0, 8'h0c, 32'h0);
    chk("heldst3", 1'b1, rv[7]);
    sns(3, 12'h100);
    wb(1'b1, 8'h08, 32'h8);
    chk("noclr3", 1'b0, pwire[3]);
    sns(3, 12'h800);
    wb(1'b1, 8'h08, 32'h8);
    chk("clr3", 1'b1, pwire[3]);
    $display("test latch done");
  endtask : t_latch
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_ref;
    t_modes;
    t_pin;
    t_latch;
    end_sim;
  end
endmodule : cmpctl_top_tb
bind cmpctl_top cmpctl_props #(.NCH(NCH), .DATA_W(DATA_W)) i_props (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .int_ref_en_o(int_ref_en_o),
  .mode_input_disable_o(mode_input_disable_o), .chan_o(chan_o), .code_o(code_o),
  .cmp_pin_oe_o(cmp_pin_oe_o));
`default_nettype wire
